// >>> common/ssa_params.svh
// constants for the slave status and access block
// assumes inclusion by bare name from the design files
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH
// register bus offsets
`define SSA_STAT_OFS    32'h0004_9280
`define SSA_CTRL_OFS    32'h0004_9224
// access control layout and reset value
`define SSA_CTRL_RST    8'hA0
`define SSA_CTRL_WMASK  8'hFC
`define SSA_INTERNAL_WRITE_SIZE_HI    5
`define SSA_INTERNAL_WRITE_SIZE_LO    4
`define SSA_READ_AUTO_INCREMENT_BIT    3
`define SSA_WRITE_AUTO_INCREMENT_BIT    2
`define SSA_INTERNAL_WRITE_SIZE_4B    2'h2
// summary status layout
`define SSA_STAT_HARD   32'h8000_0000
`define SSA_SW_MASK     32'h7000_0000
`define SSA_EV_MASK     32'h0E00_007F
`define SSA_STAT_MASK   32'hFE00_007F
// peripheral byte addresses
`define SSA_PA_WADDR0   8'h00
`define SSA_PA_WADDR3   8'h03
`define SSA_PA_WDATA0   8'h04
`define SSA_PA_WDATA3   8'h07
`define SSA_PA_RADDR0   8'h10
`define SSA_PA_RADDR3   8'h13
`define SSA_PA_RDATA0   8'h14
`define SSA_PA_RDATA3   8'h17
`define SSA_PA_CTRL     8'h24
`define SSA_PA_STAT0    8'h80
`define SSA_PA_STAT3    8'h83
// internal address step
`define SSA_ADDR_STEP   32'h0000_0004
`endif

// >>> common/ssa_pkg.sv
// types for the slave status and access block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ssa_pkg;
   // internal read fetch sequence
   typedef enum logic [2:0] {
      SSA_ST_IDLE  = 3'h1,
      SSA_ST_FETCH = 3'h2,
      SSA_ST_CAPT  = 3'h4
   } ssa_rd_state_t;
endpackage
`default_nettype wire

// >>> logic/ssa_status_access.sv
// slave-port status and internal access logic
// assumes a byte-level slave engine on the link clock and same-clock event sources
//
// Functional notes
// RQ1 - four-byte size writes internally on byte 0x07
// RQ2 - reserved write sizes block internal writes
// RQ3 - read auto-increment adds four after 0x14
// RQ4 - no read increment keeps read address
// RQ5 - read window pointer wraps 0x17 to 0x14
// RQ6 - write auto-increment adds four after 0x07
// RQ7 - write window pointer wraps 0x07 to 0x04
// RQ8 - no write increment keeps write address
// RQ9 - enabled status rising sets alert flag
// RQ10 - answer alert address only when enabled
// RQ11 - alert clears when enabled status is zero
// RQ12 - alert answer clears flag until new change
// RQ13 - status read-only on bus except software bits, slave W1C
// RQ14 - event bits sticky, active event survives clear
// RQ15 - software bits bus-written, slave-cleared
// RQ16 - software write beats slave clear
// RQ17 - status at slave addresses 0x80-0x83
// RQ18 - soft reset clears all status
// RQ19 - hard reset sets bit 31, soft clears
// RQ20 - enable rising over set status alerts
// RQ21 - alert asserts right after hard reset
// RQ22 - master clears handled events after alerts
`timescale 1ns/1ps
`default_nettype none
`include "ssa_params.svh"
module ssa_status_access
   import ssa_pkg::*;
(
   // clock and resets
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        softRst,
   // slave byte engine, link clock domain
   input  wire logic        linkClk,
   input  wire logic        linkAddrStb,
   input  wire logic        linkWrStb,
   input  wire logic        linkRdStb,
   input  wire logic        linkAraStb,
   input  wire logic [7:0]  linkByte,
   output var  logic [7:0]  linkRdData_r,
   output var  logic        araAck_r,
   // chip events and configuration
   input  wire logic [31:0] eventIn,
   input  wire logic [31:0] statEnable,
   input  wire logic        alertResponseEnable,
   output var  logic        alertFlag_r,
   // register bus slave
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [31:0] regAddr,
   input  wire logic [31:0] regWrData,
   output var  logic [31:0] regRdData_r,
   // internal register access master
   output var  logic        intWrStb_r,
   output var  logic [31:0] intWrAddr_r,
   output var  logic [31:0] intWrData_r,
   output var  logic        intRdStb_r,
   output var  logic [31:0] intRdAddr_r,
   input  wire logic [31:0] intRdData
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] byteOf(input logic [31:0] w, input logic [1:0] idx);
      byteOf = w[{idx, 3'h0} +: 8];
   endfunction

   function automatic logic [31:0] putByte(input logic [31:0] w, input logic [1:0] idx,
                                           input logic [7:0] b);
      logic [31:0] t;
      t = w;
      t[{idx, 3'h0} +: 8] = b;
      putByte = t;
   endfunction

   // data windows wrap so a burst stays inside one four-byte window
   function automatic logic [7:0] nextPtr(input logic [7:0] p);
      if (p == `SSA_PA_WDATA3) begin
         nextPtr = `SSA_PA_WDATA0; // RQ7
      end else if (p == `SSA_PA_RDATA3) begin
         nextPtr = `SSA_PA_RDATA0; // RQ5
      end else begin
         nextPtr = p + 8'h01;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // link synchroniser and edge detect

   logic        linkClkS1_r;
   logic        linkClkS2_r;
   logic        linkClkLast_r;
   logic [11:0] linkInS1_r;
   logic [11:0] linkInS2_r;

   // strobes and byte must be held across the link edge for at least 3 core cycles
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         linkClkS1_r   <= 1'b0;
         linkClkS2_r   <= 1'b0;
         linkClkLast_r <= 1'b0;
         linkInS1_r    <= 12'h000;
         linkInS2_r    <= 12'h000;
      end else begin
         linkClkS1_r   <= linkClk;
         linkClkS2_r   <= linkClkS1_r;
         linkClkLast_r <= linkClkS2_r;
         linkInS1_r    <= {linkAraStb, linkRdStb, linkWrStb, linkAddrStb, linkByte};
         linkInS2_r    <= linkInS1_r;
      end
   end

   logic       linkEdge;
   logic       evAddr;
   logic       evWr;
   logic       evRd;
   logic       evAra;
   logic [7:0] inByte;
   assign linkEdge = linkClkS2_r & ~linkClkLast_r;
   assign evAddr   = linkEdge & linkInS2_r[8];
   assign evWr     = linkEdge & linkInS2_r[9];
   assign evRd     = linkEdge & linkInS2_r[10];
   assign evAra    = linkEdge & linkInS2_r[11];
   assign inByte   = linkInS2_r[7:0];

   ////////////////////////////////////////////////////////////////////////////////
   // peripheral pointer and access control

   logic [7:0] ptr_r;
   logic [7:0] ctrl_r;
   logic       wsizeOk;
   logic       read_auto_increment;
   logic       write_auto_increment;
   assign wsizeOk = (ctrl_r[`SSA_INTERNAL_WRITE_SIZE_HI:`SSA_INTERNAL_WRITE_SIZE_LO] == `SSA_INTERNAL_WRITE_SIZE_4B);
   assign read_auto_increment    = ctrl_r[`SSA_READ_AUTO_INCREMENT_BIT];
   assign write_auto_increment    = ctrl_r[`SSA_WRITE_AUTO_INCREMENT_BIT];

   // pointer loads on the address byte, advances on each data byte
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ptr_r <= 8'h00;
      end else if (evAddr) begin
         ptr_r <= inByte;
      end else if (evWr || evRd) begin
         ptr_r <= nextPtr(ptr_r); // RQ5 RQ7
      end
   end

   // control byte is writable from the slave port only, reserved bits stay zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `SSA_CTRL_RST;
      end else if (evWr && ptr_r == `SSA_PA_CTRL) begin
         ctrl_r <= inByte & `SSA_CTRL_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // internal write path

   logic [31:0] wAddr_r;
   logic [31:0] wData_r;
   logic        wordWr;
   assign wordWr = evWr && (ptr_r == `SSA_PA_WDATA3);

   // write address, bumped after the most significant data byte
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wAddr_r <= 32'h0000_0000;
      end else if (evWr && ptr_r <= `SSA_PA_WADDR3) begin
         wAddr_r <= putByte(wAddr_r, ptr_r[1:0], inByte);
      end else if (wordWr && write_auto_increment) begin // RQ8
         wAddr_r <= wAddr_r + `SSA_ADDR_STEP; // RQ6
      end
   end

   // data staging; the write fires only with the four-byte size code
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wData_r     <= 32'h0000_0000;
         intWrStb_r  <= 1'b0;
         intWrAddr_r <= 32'h0000_0000;
         intWrData_r <= 32'h0000_0000;
      end else begin
         intWrStb_r <= 1'b0;
         if (evWr && ptr_r >= `SSA_PA_WDATA0 && ptr_r <= `SSA_PA_WDATA3) begin
            wData_r <= putByte(wData_r, ptr_r[1:0], inByte);
         end
         if (wordWr && wsizeOk) begin
            intWrStb_r  <= 1'b1; // RQ1 RQ2
            intWrAddr_r <= wAddr_r;
            intWrData_r <= putByte(wData_r, 2'h3, inByte);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // summary status and alert

   logic [31:0] stat_r;
   logic [31:0] w1c;
   logic        swWr;
   logic [31:0] stat_nxt;
   assign swWr = regWrEn && (regAddr == `SSA_STAT_OFS);
   assign w1c  = (evWr && ptr_r >= `SSA_PA_STAT0 && ptr_r <= `SSA_PA_STAT3) ?
                 putByte(32'h0000_0000, ptr_r[1:0], inByte) : 32'h0000_0000; // RQ17

   // sticky events survive a clear while still active; software bits obey the bus first
   always_comb begin
      stat_nxt = stat_r & ~w1c; // RQ13
      stat_nxt = stat_nxt | (eventIn & `SSA_EV_MASK); // RQ14
      if (swWr) begin
         stat_nxt = (stat_nxt & ~`SSA_SW_MASK) | (regWrData & `SSA_SW_MASK); // RQ15 RQ16
      end
      stat_nxt = stat_nxt & `SSA_STAT_MASK;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stat_r <= `SSA_STAT_HARD; // RQ19
      end else if (softRst) begin
         stat_r <= 32'h0000_0000; // RQ18 RQ19
      end else begin
         stat_r <= stat_nxt;
      end
   end

   logic [31:0] armed;
   logic [31:0] armedLast_r;
   logic        armedRise;
   logic        araHit;
   assign armed     = stat_r & statEnable;
   assign armedRise = |(armed & ~armedLast_r); // RQ9 RQ20
   assign araHit    = evAra && alertFlag_r && alertResponseEnable; // RQ10

   // a new rise wins over the answer clearing in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         armedLast_r <= 32'h0000_0000;
         alertFlag_r <= 1'b0;
         araAck_r    <= 1'b0;
      end else begin
         armedLast_r <= armed;
         araAck_r    <= araHit; // RQ10
         if (armedRise) begin
            alertFlag_r <= 1'b1; // RQ9 RQ21
         end else if (armed == 32'h0000_0000 || araHit) begin
            alertFlag_r <= 1'b0; // RQ11 RQ12
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // internal read path and slave read data

   ssa_rd_state_t rdState_r;
   logic [31:0]   rAddr_r;
   logic [31:0]   rWord_r;
   logic [7:0]    rdMux;

   // the fetch sequence is three cycles, far inside one link period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdState_r   <= SSA_ST_IDLE;
         intRdStb_r  <= 1'b0;
         intRdAddr_r <= 32'h0000_0000;
      end else begin
         intRdStb_r <= 1'b0;
         case (rdState_r)
            SSA_ST_IDLE: begin
               if (evRd && ptr_r == `SSA_PA_RDATA0) begin
                  rdState_r   <= SSA_ST_FETCH;
                  intRdStb_r  <= 1'b1;
                  intRdAddr_r <= rAddr_r;
               end
            end
            SSA_ST_FETCH: begin
               rdState_r <= SSA_ST_CAPT;
            end
            SSA_ST_CAPT: begin
               rdState_r <= SSA_ST_IDLE;
            end
            default: begin
               rdState_r <= SSA_ST_IDLE;
            end
         endcase
      end
   end

   // read address, stepped once the fetched word is captured
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rAddr_r <= 32'h0000_0000;
         rWord_r <= 32'h0000_0000;
      end else begin
         if (rdState_r == SSA_ST_CAPT) begin
            rWord_r <= intRdData;
            if (read_auto_increment) begin // RQ4
               rAddr_r <= rAddr_r + `SSA_ADDR_STEP; // RQ3
            end
         end else if (evWr && ptr_r >= `SSA_PA_RADDR0 && ptr_r <= `SSA_PA_RADDR3) begin
            rAddr_r <= putByte(rAddr_r, ptr_r[1:0], inByte);
         end
      end
   end

   // unmapped peripheral addresses read as zero
   always_comb begin
      rdMux = 8'h00;
      if (ptr_r <= `SSA_PA_WADDR3) begin
         rdMux = byteOf(wAddr_r, ptr_r[1:0]);
      end else if (ptr_r <= `SSA_PA_WDATA3) begin
         rdMux = byteOf(wData_r, ptr_r[1:0]);
      end else if (ptr_r >= `SSA_PA_RADDR0 && ptr_r <= `SSA_PA_RADDR3) begin
         rdMux = byteOf(rAddr_r, ptr_r[1:0]);
      end else if (ptr_r >= `SSA_PA_RDATA0 && ptr_r <= `SSA_PA_RDATA3) begin
         rdMux = byteOf(rWord_r, ptr_r[1:0]);
      end else if (ptr_r == `SSA_PA_CTRL) begin
         rdMux = ctrl_r;
      end else if (ptr_r >= `SSA_PA_STAT0 && ptr_r <= `SSA_PA_STAT3) begin
         rdMux = byteOf(stat_r, ptr_r[1:0]);
      end
   end

   // byte 0x14 returns the freshly fetched word, others the live register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         linkRdData_r <= 8'h00;
      end else if (rdState_r == SSA_ST_CAPT) begin
         linkRdData_r <= intRdData[7:0];
      end else if (evRd && ptr_r != `SSA_PA_RDATA0) begin
         linkRdData_r <= rdMux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register bus read side; control is read-only on this bus, status takes bus writes on its software bits only

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regRdData_r <= 32'h0000_0000;
      end else if (regRdEn) begin
         if (regAddr == `SSA_STAT_OFS) begin
            regRdData_r <= stat_r; // RQ13
         end else if (regAddr == `SSA_CTRL_OFS) begin
            regRdData_r <= {24'h00_0000, ctrl_r};
         end else begin
            regRdData_r <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   AST_WORD_WRITE: assert property (wordWr && wsizeOk |=> intWrStb_r && // RQ1
                                    intWrData_r[31:24] == $past(inByte))
      else $error("four-byte write not issued");
   AST_INTERNAL_WRITE_SIZE_OFF: assert property (!wsizeOk |=> !intWrStb_r) // RQ2
      else $error("internal write with reserved size");
   AST_READ_AUTO_INCREMENT: assert property (rdState_r == SSA_ST_CAPT && read_auto_increment |=> // RQ3
                              rAddr_r == $past(rAddr_r) + `SSA_ADDR_STEP)
      else $error("read address not stepped");
   AST_RHOLD: assert property (intRdStb_r && !read_auto_increment && !evWr ##1 !evWr ##1 !evWr |=> // RQ4
                               rAddr_r == $past(rAddr_r, 3))
      else $error("read address moved without increment");
   AST_RWRAP: assert property (evRd && ptr_r == `SSA_PA_RDATA3 |=> // RQ5
                               ptr_r == `SSA_PA_RDATA0)
      else $error("read window did not wrap");
   AST_WRITE_AUTO_INCREMENT: assert property (wordWr && write_auto_increment |=> // RQ6
                              wAddr_r == $past(wAddr_r) + `SSA_ADDR_STEP)
      else $error("write address not stepped");
   AST_WWRAP: assert property (evWr && ptr_r == `SSA_PA_WDATA3 |=> // RQ7
                               ptr_r == `SSA_PA_WDATA0)
      else $error("write window did not wrap");
   AST_WHOLD: assert property (wordWr && !write_auto_increment |=> $stable(wAddr_r)) // RQ8
      else $error("write address moved without increment");
   AST_ALERT_SET: assert property (armedRise |=> alertFlag_r) // RQ9
      else $error("alert not raised on enabled rise");
   AST_ARA_GATE: assert property (evAra && !alertResponseEnable |=> !araAck_r) // RQ10
      else $error("alert answered while disabled");
   AST_ALERT_CLR: assert property (armed == 32'h0000_0000 |=> !alertFlag_r) // RQ11
      else $error("alert held with no enabled status");
   AST_ARA_CLR: assert property (araHit && !armedRise |=> !alertFlag_r) // RQ12
      else $error("alert not cleared by answer");
   AST_EVENT_HOLD: assert property (!softRst && (eventIn & `SSA_EV_MASK) != 32'h0 |=> // RQ14
                                    ($past(eventIn) & `SSA_EV_MASK & ~stat_r) == 32'h0)
      else $error("active event lost");
   AST_SW_WIN: assert property (swWr && !softRst |=> // RQ16
                                (stat_r & `SSA_SW_MASK) == ($past(regWrData) & `SSA_SW_MASK))
      else $error("software value lost");
   AST_SOFT_CLR: assert property (softRst |=> stat_r == 32'h0000_0000) // RQ18
      else $error("soft reset left status");

endmodule
`default_nettype wire

// >>> sim/ssa_link_master.sv
// behavioural byte-level link master facing the slave status block
// assumes the block samples these pins on its own clock, 2-3 cycles late
`timescale 1ns/1ps
`default_nettype none
module ssa_link_master (
   // link pins toward the block
   output var logic       linkClk,
   output var logic       linkAddrStb,
   output var logic       linkWrStb,
   output var logic       linkRdStb,
   output var logic       linkAraStb,
   output var logic [7:0] linkByte,
   // read byte from the block
   input  wire logic [7:0] linkRdData_r
);
   ////////////////////////////////////////////////////////////////////////////////
   // idle: clock stands low outside transfers
   initial begin
      linkClk = 1'b0;
      {linkAraStb, linkRdStb, linkWrStb, linkAddrStb} = 4'h0;
      linkByte = 8'h00;
   end

   // one byte: k 0 address, 1 write, 2 read, 3 alert answer; 48 ns period,
   // stretched low after a read so the fetched byte has time to land
   task automatic xfer(input int k, input logic [7:0] b, output logic [7:0] rd);
      {linkAraStb, linkRdStb, linkWrStb, linkAddrStb} = 4'(1 << k);
      linkByte = b;
      #12;
      linkClk = 1'b1;
      #24;
      linkClk = 1'b0;
      {linkAraStb, linkRdStb, linkWrStb, linkAddrStb} = 4'h0;
      linkByte = ~b;  // released lines must not keep the last value
      #(k == 2 ? 36 : 12);
      rd = linkRdData_r;
   endtask
endmodule
`default_nettype wire

// >>> sim/tb_i2c_slave_status_alert_access.sv
// self-checking bench for the slave status and access block
// assumes ssa_pkg, ssa_params.svh and ssa_link_master are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "ssa_params.svh"
module tb_i2c_slave_status_alert_access;
   import ssa_pkg::*;
   localparam logic [31:0] RDX = 32'h5A3C_0000;
   logic        core_clk, rst, softRst, alertResponseEnable;
   logic        regWrEn, regRdEn, rdPend;
   logic [31:0] eventIn, statEnable, regAddr, regWrData, intRdData;
   logic [31:0] a;
   logic [63:0] d, r;
   logic [1:0]  codes [5] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h3};
   wire logic        linkClk, linkAddrStb, linkWrStb, linkRdStb, linkAraStb;
   wire logic [7:0]  linkByte, linkRdData_r;
   wire logic        araAck_r, alertFlag_r, intWrStb_r, intRdStb_r;
   wire logic [31:0] regRdData_r, intWrAddr_r, intWrData_r, intRdAddr_r;
   logic [63:0] wq [$];  // expected internal writes {addr,data}
   logic [31:0] rq [$];  // expected register reads
   logic        aq [$];  // expected alert answers
   logic [31:0] fq [$];  // expected internal read addresses
   int          err_total = 0;
   int          check_count = 0;

   ssa_status_access dut (.core_clk, .rst, .softRst, .linkClk, .linkAddrStb, .linkWrStb,
      .linkRdStb, .linkAraStb, .linkByte, .linkRdData_r, .araAck_r, .eventIn, .statEnable,
      .alertResponseEnable, .alertFlag_r, .regWrEn, .regRdEn, .regAddr, .regWrData,
      .regRdData_r, .intWrStb_r, .intWrAddr_r, .intWrData_r, .intRdStb_r, .intRdAddr_r,
      .intRdData);
   ssa_link_master m (.linkClk, .linkAddrStb, .linkWrStb, .linkRdStb, .linkAraStb,
      .linkByte, .linkRdData_r);

   ////////////////////////////////////////////////////////////////////////////////
   // clock, internal read responder, watchdog
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) intRdData <= intRdAddr_r ^ RDX;
   // tests take about 7.5 us; a hang is cut well beyond that
   initial begin
      #100us;
      err_total++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare, report, finish
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // output monitor: every result takes the oldest note off its queue
   always @(posedge core_clk) rdPend <= regRdEn;
   always @(negedge core_clk) begin
      if (rdPend === 1'b1)
         chk("regRdData", rq.size() ? rq.pop_front() : 'x, regRdData_r);
      if (intWrStb_r === 1'b1)
         chk("intWr", wq.size() ? wq.pop_front() : 'x, {intWrAddr_r, intWrData_r});
      if (araAck_r === 1'b1)
         chk("araAck", aq.size() ? 64'(aq.pop_front()) : 'x, 64'h1);
      if (intRdStb_r === 1'b1)
         chk("intRdAddr", fq.size() ? fq.pop_front() : 'x, intRdAddr_r);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // drivers: register bus strobe, link byte sequences
   task automatic reg_op(input logic wr, input logic [31:0] ad, input logic [31:0] v);
      @(negedge core_clk);
      regWrEn = wr;
      regRdEn = !wr;
      regAddr = ad;
      regWrData = v;
      if (!wr)
         rq.push_back(v);
      @(negedge core_clk);
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   endtask
   task automatic lwr(input logic [7:0] pa, input logic [63:0] w, input int n);
      logic [7:0] rd;
      m.xfer(0, pa, rd);
      for (int i = 0; i < n; i++)
         m.xfer(1, w[8*i +: 8], rd);
   endtask
   task automatic lrd(input logic [7:0] pa, output logic [63:0] w);
      logic [7:0] rd;
      m.xfer(0, pa, rd);
      for (int i = 0; i < 8; i++) begin
         m.xfer(2, 8'h00, rd);
         w[8*i +: 8] = rd;
      end
   endtask
   task automatic alert_is(input logic v);
      repeat (3) @(negedge core_clk);
      chk("alertFlag", v, alertFlag_r);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {rst, softRst, alertResponseEnable, regWrEn, regRdEn} = 5'h10;
      {eventIn, regAddr, regWrData} = '0;
      statEnable = 32'hFFFF_FFFF;
      a = $urandom(32'hCE8C);
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      alert_is(1'b1);
      reg_op(0, `SSA_STAT_OFS, `SSA_STAT_HARD);
      reg_op(0, `SSA_CTRL_OFS, 32'h0000_00A0);
      reg_op(0, 32'h0004_9300, 32'h0);
      lwr(8'h83, 64'h80, 1);
      alert_is(1'b0);
      // bus writes reach only the software bits
      reg_op(1, `SSA_STAT_OFS, 32'hFFFF_FFFF);
      reg_op(0, `SSA_STAT_OFS, `SSA_SW_MASK);
      alert_is(1'b1);
      lrd(8'h80, r);
      chk("linkStat", {32'h0, `SSA_SW_MASK}, r);
      lwr(8'h83, 64'h70, 1);
      reg_op(0, `SSA_STAT_OFS, 32'h0);
      alert_is(1'b0);
      // events stick; an active event survives its clear
      eventIn = 32'h0000_0050;
      lwr(8'h80, 64'h50, 1);
      @(negedge core_clk) eventIn = 32'h0;
      reg_op(0, `SSA_STAT_OFS, 32'h50);
      lwr(8'h80, 64'h10, 1);
      reg_op(0, `SSA_STAT_OFS, 32'h40);
      alert_is(1'b1);
      // alert answer only when enabled, then flag stays down
      m.xfer(3, 8'h19, r[7:0]);
      alert_is(1'b1);
      alertResponseEnable = 1'b1;
      aq.push_back(1'b1);
      m.xfer(3, 8'h19, r[7:0]);
      alert_is(1'b0);
      alert_is(1'b0);
      statEnable = 32'h0;
      @(negedge core_clk);
      statEnable = 32'hFFFF_FFFF;
      alert_is(1'b1);
      statEnable = 32'hFFFF_FFBF;
      alert_is(1'b0);
      statEnable = 32'hFFFF_FFFF;
      // soft reset clears all status, software bits included
      reg_op(1, `SSA_STAT_OFS, 32'h1000_0000);
      @(negedge core_clk);
      softRst = 1'b1;
      @(negedge core_clk);
      softRst = 1'b0;
      reg_op(0, `SSA_STAT_OFS, 32'h0);
      alert_is(1'b0);
      // write size codes, auto-increment on and off, window wrap
      for (int k = 0; k < 5; k++) begin
         lwr(8'h24, {56'h0, 2'h2, codes[k], 1'b0, k == 1, 2'h0}, 1);
         a = $urandom & 32'h000F_FFFC;
         d = {$urandom, $urandom};
         if (codes[k] == `SSA_INTERNAL_WRITE_SIZE_4B) begin
            wq.push_back({a, d[31:0]});
            wq.push_back({k == 1 ? a + `SSA_ADDR_STEP : a, d[63:32]});
         end
         lwr(8'h00, {32'h0, a}, 4);
         lwr(8'h04, d, 8);
         repeat (8) @(negedge core_clk);
         chk("wqLeft", 64'h0, 64'(wq.size()));
      end
      // read auto-increment off and on, read window wrap
      for (int k = 0; k < 2; k++) begin
         lwr(8'h24, {56'h0, 2'h2, 2'h2, k == 1, 1'b0, 2'h0}, 1);
         a = $urandom & 32'h000F_FFFC;
         lwr(8'h10, {32'h0, a}, 4);
         fq.push_back(a);
         fq.push_back(k == 1 ? a + `SSA_ADDR_STEP : a);
         lrd(8'h14, r);
         chk("rdWords", {(k == 1 ? a + `SSA_ADDR_STEP : a) ^ RDX, a ^ RDX}, r);
      end
      repeat (8) @(negedge core_clk);
      chk("aqLeft", 64'h0, 64'(aq.size()));
      chk("fqLeft", 64'h0, 64'(fq.size()));
      end_of_test();
   end
endmodule
`default_nettype wire
